// *** pkg/pll_status_pkg.sv ***
// Shared constants for the PLL status and global interrupt register bank
package pll_status_pkg;

  // Register port widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [15:0] OFS_PLL_B_STATUS  = 16'h020f;
  localparam logic [15:0] OFS_GP_INPUTS     = 16'h0219;
  localparam logic [15:0] OFS_IRQ_SUMMARY   = 16'h021a;
  localparam logic [15:0] OFS_BOOT_FAIL     = 16'h021e;
  localparam logic [15:0] OFS_EEPROM_STATUS = 16'h021f;

  // Field positions inside the second PLL status byte
  localparam int PLL_B_REF_LSB  = 0;
  localparam int PLL_B_REF_W    = 3;
  localparam int PLL_B_LOST_BIT = 4;

  // Selected reference encodings
  localparam logic [2:0] REF_NONE_MAX = 3'h3;
  localparam logic [2:0] REF_IN_A     = 3'h4;
  localparam logic [2:0] REF_IN_B     = 3'h5;

  // General-purpose input field
  localparam int GP_PINS    = 4;
  localparam int GP_LSB     = 0;

  // Global status bit positions
  localparam int IRQ_SUM_BIT   = 0;
  localparam int BOOT_FAIL_BIT = 0;
  localparam int LOAD_DONE_BIT = 0;
  localparam int CRC_OK_N_BIT  = 3;

  // Number of per-event sticky interrupt sources
  localparam int IRQ_EVENTS = 8;

  // Reset and idle values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] GP_RESET  = 4'h0;
  localparam logic [7:0] IRQ_RESET = 8'h00;

endpackage

// *** core/pin_sync3.sv ***
`timescale 1ns/1ps
// Three-stage pin synchroniser with agreement filter
module pin_sync3 #(
  parameter int WIDTH = 4
) (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Asynchronous pins in
  input  wire logic [WIDTH-1:0] pin_async,
  // Filtered level out
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;  // Metastable catch, read only by stage2
  logic [WIDTH-1:0] stage2;  // Second stage
  logic [WIDTH-1:0] stage3;  // Third stage

  // Shift chain
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else if (ce) begin
      stage1 <= pin_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Take a new level per bit once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= '0;
    end else if (ce) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end

endmodule

// *** core/pll_status_and_global_irq_regs.sv ***
`timescale 1ns/1ps
// What this block does
// - Low three bits report second PLL reference
// - Bit four flags lost feedback loop
// - Low nibble shows general input pin levels
// - Summary bit and low pin on enabled irq
// - Boot failure flag sticky until reset
// - Load complete flag sticky until reset
// - Active-low checksum flag reads 0 on error
// - Checksum failure locks serial configuration port
// - Reserved bits written zero, read ignored
// - Event status sticky, write-one clears
module pll_status_and_global_irq_regs (
  // Clock, reset, enable
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  input  wire logic                                   ce,
  // Register port
  input  wire logic [pll_status_pkg::ADDR_W-1:0]      reg_addr,
  input  wire logic                                   reg_rd,
  input  wire logic                                   reg_wr,
  input  wire logic [pll_status_pkg::DATA_W-1:0]      reg_wdata,
  output logic      [pll_status_pkg::DATA_W-1:0]      reg_rdata,
  output logic                                        reg_rvalid,
  // Second PLL state, same clock
  input  wire logic [pll_status_pkg::PLL_B_REF_W-1:0] pll_b_selected_ref,
  input  wire logic                                   pll_b_feedback_lost,
  // General-purpose pins, asynchronous
  input  wire logic [pll_status_pkg::GP_PINS-1:0]     gp_pins,
  input  wire logic [pll_status_pkg::GP_PINS-1:0]     gp_is_input,
  // Interrupt sources and software controls
  input  wire logic [pll_status_pkg::IRQ_EVENTS-1:0]  irq_event,
  input  wire logic [pll_status_pkg::IRQ_EVENTS-1:0]  irq_enable,
  input  wire logic [pll_status_pkg::IRQ_EVENTS-1:0]  irq_clear,
  output logic      [pll_status_pkg::IRQ_EVENTS-1:0]  irq_status,
  // Interrupt pin, open drain
  output logic                                        irq_pin_n_out,
  output logic                                        irq_pin_n_oe,
  // EEPROM loader results, one-cycle pulses
  input  wire logic                                   rom_read_failed,
  input  wire logic                                   rom_cycle_done,
  input  wire logic                                   rom_crc_failed,
  // Derived status
  output logic                                        config_port_locked,
  output logic                                        pll_b_on_ref_a,
  output logic                                        pll_b_on_ref_b
);

  // Synchronised general-purpose pin levels
  logic [pll_status_pkg::GP_PINS-1:0] gp_sync;

  // Captured general-purpose input levels
  logic [pll_status_pkg::GP_PINS-1:0] gp_input_levels;

  // Second PLL status captured each cycle
  logic [pll_status_pkg::PLL_B_REF_W-1:0] ref_code;
  logic                                   feedback_lost;

  // Interrupt summary flop
  logic irq_summary;

  // EEPROM result flags
  logic boot_load_failed;
  logic rom_load_complete;
  logic rom_checksum_ok_n;

  // Next interrupt status
  logic [pll_status_pkg::IRQ_EVENTS-1:0] next_irq_status;

  // Enabled events that will stand after this edge
  logic [pll_status_pkg::IRQ_EVENTS-1:0] pending_enabled;

  // Next read data
  logic [pll_status_pkg::DATA_W-1:0] next_rdata;

  // Status byte builder for the second PLL
  function automatic logic [7:0] pll_b_byte(
    input logic [2:0] code,
    input logic       lost
  );
    logic [7:0] b;
    b = pll_status_pkg::BYTE_ZERO;
    // Reference code in the low bits
    b[pll_status_pkg::PLL_B_REF_LSB +: pll_status_pkg::PLL_B_REF_W] =
      code;
    // Lost feedback flag
    b[pll_status_pkg::PLL_B_LOST_BIT] = lost;
    return b;
  endfunction

  // Single-bit status byte builder, other bits reserved as zero
  function automatic logic [7:0] bit_byte(
    input int   pos,
    input logic val
  );
    logic [7:0] b;
    b = pll_status_pkg::BYTE_ZERO;
    b[pos[2:0]] = val;
    return b;
  endfunction

  // True when the reference code equals the wanted code
  function automatic logic ref_is(
    input logic [pll_status_pkg::PLL_B_REF_W-1:0] code,
    input logic [pll_status_pkg::PLL_B_REF_W-1:0] want
  );
    return code == want;
  endfunction

  // Set-only flag update; reset is the only way back
  function automatic logic sticky_set(
    input logic held,
    input logic hit
  );
    return held | hit;
  endfunction

  // Pin synchroniser for the general-purpose inputs
  pin_sync3 #(
    .WIDTH (pll_status_pkg::GP_PINS)
  ) i_pin_sync3 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .pin_async (gp_pins),
    .level     (gp_sync)
  );

  // Capture levels of pins set as inputs; outputs read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      // Pins read low until the chain has filled
      gp_input_levels <= pll_status_pkg::GP_RESET;
    end else if (ce) begin
      // Output-configured pins are masked to zero
      gp_input_levels <= gp_sync & gp_is_input;
    end
  end

  // Capture the second PLL state for reads
  always_ff @(posedge clk) begin
    if (rst) begin
      // Neither reference, loop intact
      ref_code      <= '0;
      feedback_lost <= 1'b0;
    end else if (ce) begin
      // Same clock, so no synchroniser needed
      ref_code      <= pll_b_selected_ref;
      feedback_lost <= pll_b_feedback_lost;
    end
  end

  // Decoded reference flags; codes 0-3 and 6-7 mean neither
  always_ff @(posedge clk) begin
    if (rst) begin
      // No reference selected after reset
      pll_b_on_ref_a <= 1'b0;
      pll_b_on_ref_b <= 1'b0;
    end else if (ce) begin
      // Only the two live input codes light a flag
      pll_b_on_ref_a <= ref_is(pll_b_selected_ref,
                               pll_status_pkg::REF_IN_A);
      pll_b_on_ref_b <= ref_is(pll_b_selected_ref,
                               pll_status_pkg::REF_IN_B);
    end
  end

  // Sticky event bits; a new event beats a clear in the same cycle
  always_comb begin
    next_irq_status = (irq_status & ~irq_clear) | irq_event;
  end

  // Event status register
  always_ff @(posedge clk) begin
    if (rst) begin
      // All event bits clear at reset
      irq_status <= pll_status_pkg::IRQ_RESET;
    end else if (ce) begin
      // Set and clear taken together
      irq_status <= next_irq_status;
    end
  end

  // Enabled share of the next event status
  always_comb begin
    pending_enabled = next_irq_status & irq_enable;
  end

  // Summary of enabled event bits
  always_ff @(posedge clk) begin
    if (rst) begin
      // Pin released after reset
      irq_summary <= 1'b0;
    end else if (ce) begin
      // Moves on the same edge as the event bits
      irq_summary <= |pending_enabled;
    end
  end

  // Open-drain pin: pull low while summary is set, else release
  always_comb begin
    // Never driven high; only the enable moves
    irq_pin_n_out = 1'b0;
    irq_pin_n_oe  = irq_summary;
  end

  // Boot failure flag, cleared only by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      // Device reset is the only clear
      boot_load_failed <= 1'b0;
    end else if (ce) begin
      // A failed read sets it for good
      boot_load_failed <= sticky_set(boot_load_failed,
                                     rom_read_failed);
    end
  end

  // Load complete flag, cleared only by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      // Nothing loaded yet
      rom_load_complete <= 1'b0;
    end else if (ce) begin
      // End of the read cycle sets it for good
      rom_load_complete <= sticky_set(rom_load_complete,
                                      rom_cycle_done);
    end
  end

  // Active-low checksum flag, held low after an error until reset
  always_ff @(posedge clk) begin
    if (rst) begin
      // No checksum error seen yet
      rom_checksum_ok_n <= 1'b1;
    end else if (ce) begin
      // A checksum error pulls it low until reset
      rom_checksum_ok_n <= ~sticky_set(~rom_checksum_ok_n,
                                       rom_crc_failed);
    end
  end

  // Serial configuration port lock; reset is the only way out
  always_comb begin
    // Follows the checksum flag, so only reset frees it
    config_port_locked = ~rom_checksum_ok_n;
  end

  // Read data mux; reserved and unmapped positions read zero
  always_comb begin
    next_rdata = pll_status_pkg::BYTE_ZERO;
    case (reg_addr)
      pll_status_pkg::OFS_PLL_B_STATUS: begin
        // Reference code and lost-loop flag
        next_rdata = pll_b_byte(ref_code, feedback_lost);
      end
      pll_status_pkg::OFS_GP_INPUTS: begin
        // Filtered input pin levels
        next_rdata[pll_status_pkg::GP_LSB +: pll_status_pkg::GP_PINS] =
          gp_input_levels;
      end
      pll_status_pkg::OFS_IRQ_SUMMARY: begin
        // Device interrupt summary
        next_rdata = bit_byte(pll_status_pkg::IRQ_SUM_BIT,
                              irq_summary);
      end
      pll_status_pkg::OFS_BOOT_FAIL: begin
        // Sticky boot failure
        next_rdata = bit_byte(pll_status_pkg::BOOT_FAIL_BIT,
                              boot_load_failed);
      end
      pll_status_pkg::OFS_EEPROM_STATUS: begin
        // Load done and active-low checksum flag
        next_rdata = bit_byte(pll_status_pkg::LOAD_DONE_BIT,
                              rom_load_complete);
        next_rdata[pll_status_pkg::CRC_OK_N_BIT] =
          rom_checksum_ok_n;
      end
      default: begin
        // Unmapped bytes read zero
        next_rdata = pll_status_pkg::BYTE_ZERO;
      end
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      // Nothing to answer after reset
      reg_rdata  <= pll_status_pkg::BYTE_ZERO;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      // Answer flag one edge after the strobe
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        // Data holds until the next read
        reg_rdata <= next_rdata;
      end
    end
  end

  // Only reads move the answer above; reg_wr and reg_wdata
  // steer no state, so writes to read-only bytes and to
  // reserved bits change nothing

endmodule

// *** verification/pll_status_and_global_irq_regs_props.sv ***
`timescale 1ns/1ps
// Port checks of the status register bank
module pll_status_and_global_irq_regs_props (
  // Clock and control
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  // Status sources and results
  input wire logic [2:0]  pll_b_selected_ref,
  input wire logic [7:0]  irq_event,
  input wire logic [7:0]  irq_enable,
  input wire logic [7:0]  irq_clear,
  input wire logic [7:0]  irq_status,
  input wire logic        irq_pin_n_out,
  input wire logic        irq_pin_n_oe,
  input wire logic        rom_crc_failed,
  input wire logic        config_port_locked,
  input wire logic        pll_b_on_ref_a,
  input wire logic        pll_b_on_ref_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Accepted read, any byte
  sequence rd_any_s;
    ce && reg_rd;
  endsequence
  // Accepted read of the loader status byte
  sequence rd_rom_s;
    rd_any_s ##0 reg_addr == pll_status_pkg::OFS_EEPROM_STATUS;
  endsequence
  AST_RVALID: assert property (rd_any_s |=> reg_rvalid)
    else $error("read not answered");
  AST_REF_A: assert property (ce |=> pll_b_on_ref_a ==
    ($past(pll_b_selected_ref) == pll_status_pkg::REF_IN_A))
    else $error("ref a flag wrong");
  AST_REF_B: assert property (ce |=> pll_b_on_ref_b ==
    ($past(pll_b_selected_ref) == pll_status_pkg::REF_IN_B))
    else $error("ref b flag wrong");
  AST_PIN_DRIVE: assert property (irq_pin_n_out == 1'b0)
    else $error("irq pin drives high");
  AST_SUMMARY: assert property ($stable(irq_enable) |->
    irq_pin_n_oe == |(irq_status & irq_enable))
    else $error("irq pin mismatch");
  AST_SET: assert property (ce && |irq_event |=>
    (irq_status & $past(irq_event)) == $past(irq_event))
    else $error("event not latched");
  AST_CLR: assert property (ce && |irq_clear |=>
    (irq_status & $past(irq_clear) & ~$past(irq_event)) == 8'h00)
    else $error("clear ignored");
  AST_HOLD: assert property (!(|irq_clear) |=>
    (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("event bit lost");
  AST_LOCK: assert property (ce && rom_crc_failed |=>
    config_port_locked ##1 config_port_locked)
    else $error("lock not held");
  AST_CRC_READ: assert property (config_port_locked ##0 rd_rom_s
    |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[3])
    else $error("checksum flag wrong");
endmodule

bind pll_status_and_global_irq_regs
  pll_status_and_global_irq_regs_props
    i_pll_status_and_global_irq_regs_props (
      .clk                (clk),
      .rst                (rst),
      .ce                 (ce),
      .reg_addr           (reg_addr),
      .reg_rd             (reg_rd),
      .reg_rdata          (reg_rdata),
      .reg_rvalid         (reg_rvalid),
      .pll_b_selected_ref (pll_b_selected_ref),
      .irq_event          (irq_event),
      .irq_enable         (irq_enable),
      .irq_clear          (irq_clear),
      .irq_status         (irq_status),
      .irq_pin_n_out      (irq_pin_n_out),
      .irq_pin_n_oe       (irq_pin_n_oe),
      .rom_crc_failed     (rom_crc_failed),
      .config_port_locked (config_port_locked),
      .pll_b_on_ref_a     (pll_b_on_ref_a),
      .pll_b_on_ref_b     (pll_b_on_ref_b)
    );

// *** verification/test_pll_status_and_global_irq_regs.sv ***
`timescale 1ns/1ps
// Self-checking bench of the status register bank
module test_pll_status_and_global_irq_regs;
  // Design inputs and outputs, named as the ports
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic        reg_rd = 1'b0, reg_wr = 1'b0, reg_rvalid;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, irq_status;
  logic [2:0]  pll_b_selected_ref = 3'h0;
  logic        pll_b_feedback_lost = 1'b0;
  logic [3:0]  gp_pins = 4'h0, gp_is_input = 4'hf;
  logic [7:0]  irq_event = 8'h00, irq_enable = 8'h00, irq_clear = 8'h00;
  logic        irq_pin_n_out, irq_pin_n_oe, config_port_locked;
  logic        rom_read_failed = 1'b0, rom_cycle_done = 1'b0;
  logic        rom_crc_failed = 1'b0, pll_b_on_ref_a, pll_b_on_ref_b;
  int          n_mismatch = 0, tests_run = 0;
  // Row: address, ref code, lost, pins, input mask, expected byte
  typedef struct {
    logic [15:0] a; logic [2:0] r; logic l; logic [3:0] g, m;
    logic [7:0] e;
  } row_s;
  row_s rows [12] = '{
    '{16'h020f, 3'h0, 1'b0, 4'h0, 4'hf, 8'h00},
    '{16'h020f, 3'h1, 1'b1, 4'h0, 4'hf, 8'h11},
    '{16'h020f, 3'h2, 1'b0, 4'h0, 4'hf, 8'h02},
    '{16'h020f, 3'h3, 1'b1, 4'h0, 4'hf, 8'h13},
    '{16'h020f, 3'h4, 1'b0, 4'h0, 4'hf, 8'h04},
    '{16'h020f, 3'h5, 1'b1, 4'h0, 4'hf, 8'h15},
    '{16'h020f, 3'h6, 1'b0, 4'h0, 4'hf, 8'h06},
    '{16'h020f, 3'h7, 1'b1, 4'h0, 4'hf, 8'h17},
    '{16'h0219, 3'h0, 1'b0, 4'ha, 4'hf, 8'h0a},
    '{16'h0219, 3'h0, 1'b0, 4'h5, 4'hf, 8'h05},
    '{16'h0219, 3'h0, 1'b0, 4'hf, 4'h3, 8'h03},
    '{16'h0210, 3'h5, 1'b1, 4'hf, 4'hf, 8'h00}};

  pll_status_and_global_irq_regs i_pll_status_and_global_irq_regs (.*);

  // Free-running clock
  always #25 clk = ~clk;

  // Compare and count
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Wait whole cycles, ending on a falling edge
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  // One read; answer looked at in its own cycle
  task automatic rd(logic [15:0] a, logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk("rvalid", {7'h0, reg_rvalid}, 8'h01);
    chk("rdata", reg_rdata, e);
    // Strobe stays low one edge; the answer flag is a pulse
    tick(1);
    chk("rvalid", {7'h0, reg_rvalid}, 8'h00);
  endtask
  // Counts and verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(2000 * 50);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence
  initial begin
    tick(10);
    rst = 1'b0;
    rd(16'h021f, 8'h08);
    rd(16'h021e, 8'h00);
    rd(16'h021a, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      {pll_b_selected_ref, pll_b_feedback_lost} = {rows[i].r, rows[i].l};
      {gp_pins, gp_is_input} = {rows[i].g, rows[i].m};
      tick(6);
      rd(rows[i].a, rows[i].e);
      chk("ref_a", {7'h0, pll_b_on_ref_a}, {7'h0, rows[i].r == 3'h4});
      chk("ref_b", {7'h0, pll_b_on_ref_b}, {7'h0, rows[i].r == 3'h5});
    end
    $display("table test done");
    // Write to a read-only byte changes nothing
    reg_addr = 16'h020f;
    reg_wdata = 8'hff;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    rd(16'h020f, 8'h15);
    $display("write test done");
    // Masked event, enabled event, clear racing a new event
    irq_enable = 8'h04;
    irq_event = 8'h20;
    tick(1);
    irq_event = 8'h04;
    tick(1);
    irq_event = 8'h00;
    tick(2);
    chk("status", irq_status, 8'h24);
    chk("oe", {7'h0, irq_pin_n_oe}, 8'h01);
    chk("pin", {7'h0, irq_pin_n_out}, 8'h00);
    rd(16'h021a, 8'h01);
    irq_clear = 8'h24;
    irq_event = 8'h20;
    tick(1);
    irq_clear = 8'h00;
    irq_event = 8'h00;
    tick(2);
    chk("status", irq_status, 8'h20);
    chk("oe", {7'h0, irq_pin_n_oe}, 8'h00);
    rd(16'h021a, 8'h00);
    $display("interrupt test done");
    // Loader results, sticky until reset
    rom_cycle_done = 1'b1;
    tick(1);
    rom_cycle_done = 1'b0;
    rom_read_failed = 1'b1;
    tick(1);
    rom_read_failed = 1'b0;
    tick(2);
    rd(16'h021f, 8'h09);
    rom_crc_failed = 1'b1;
    tick(1);
    rom_crc_failed = 1'b0;
    tick(20);
    rd(16'h021e, 8'h01);
    rd(16'h021f, 8'h01);
    chk("lock", {7'h0, config_port_locked}, 8'h01);
    rst = 1'b1;
    tick(1);
    rst = 1'b0;
    rd(16'h021f, 8'h08);
    rd(16'h021e, 8'h00);
    chk("lock", {7'h0, config_port_locked}, 8'h00);
    chk("status", irq_status, 8'h00);
    $display("loader test done");
    // Enable low freezes state; events then are lost
    ce = 1'b0;
    irq_event = 8'h01;
    rom_cycle_done = 1'b1;
    tick(2);
    irq_event = 8'h00;
    rom_cycle_done = 1'b0;
    ce = 1'b1;
    tick(1);
    chk("status", irq_status, 8'h00);
    rd(16'h021f, 8'h08);
    $display("enable test done");
    end_of_test();
  end
endmodule
